//--- core/dcpbs_defs.svh
// constants for the sample clock source and oscillator band selection
// assumes byte-wide serial register port and a 100 MHz control clock
`ifndef DCPBS_DEFS_SVH
`define DCPBS_DEFS_SVH
`define DCPBS_ADDR_W          7
`define DCPBS_REG_CLKIN       7'h08
`define DCPBS_REG_PLLCTL      7'h0A
`define DCPBS_REG_BIAS        7'h0C
`define DCPBS_REG_XCTL        7'h0D
`define DCPBS_REG_STATUS      7'h0E
`define DCPBS_PLLCTL_EN       7
`define DCPBS_PLLCTL_MAN      6
`define DCPBS_XCTL_XEN        4
`define DCPBS_CLKIN_DCC       0
`define DCPBS_CLKIN_LVL       1
`define DCPBS_STAT_LOCK       7
`define DCPBS_STAT_BUSY       6
`define DCPBS_RST_PLLCTL      8'h00
`define DCPBS_RST_BIAS        8'hC9
`define DCPBS_RST_XCTL        8'h10
`define DCPBS_RST_CLKIN       8'h00
`define DCPBS_BAND_LAST       6'h3E
`define DCPBS_BAND_MID        6'h1F
`define DCPBS_BAND_FIRST      6'h00
`define DCPBS_BAND_MSB        5
`define DCPBS_BW_MSB          7
`define DCPBS_BW_LSB          5
`define DCPBS_BCTL_MSB        4
`define DCPBS_ERR_MAX         4'hF
`define DCPBS_VC_HIGH         4'hF
`define DCPBS_VC_LOW          4'h1
`define DCPBS_VC_BEST         4'h9
`define DCPBS_VC_CENTER       4'h8
`define DCPBS_SETTLE_NS       1000
`define DCPBS_CLK_NS          10
`define DCPBS_SETTLE_CYC      ((`DCPBS_SETTLE_NS + `DCPBS_CLK_NS - 1) / `DCPBS_CLK_NS)
`define DCPBS_CNT_W           8
`endif

//--- core/dcpbs_pkg.sv
// types for the sample clock source and band selection block
// assumes dcpbs_defs.svh sits beside it
`include "dcpbs_defs.svh"
package dcpbs_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_JUDGE, ST_DONE} dcpbs_st_t;
  typedef struct packed {
    logic [`DCPBS_ADDR_W-1:0] addr;
    logic                     wr;
    logic                     rd;
    logic [7:0]               wdata;
  } dcpbs_bus_t;
  typedef struct packed {
    logic       locked;
    logic [3:0] vctl;
  } dcpbs_ana_t;
  typedef struct packed {
    logic       pll_en;
    logic       use_ref;
    logic [5:0] band;
    logic [2:0] loop_bw;
    logic [4:0] bias_ctl;
    logic       cross_en;
    logic       dcc_en;
    logic       lvl_en;
  } dcpbs_ctl_t;
endpackage

//--- core/dcpbs_search.sv
// automatic oscillator band search engine
// assumes the analog lock and control-voltage code settle within a
// fixed time after each band change
`timescale 1ns/1ps
`include "dcpbs_defs.svh"
module dcpbs_search (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 start_in,
  input  wire logic                 abort_in,
  input  wire dcpbs_pkg::dcpbs_ana_t ana_in,
  output logic                      busy_out,
  output logic [5:0]                band_out
);
  import dcpbs_pkg::*;
  typedef struct packed {
    dcpbs_st_t              st;
    logic [5:0]             band;
    logic [5:0]             best;
    logic [3:0]             best_err;
    logic                   found;
    logic [`DCPBS_CNT_W-1:0] cnt;
  } dcpbs_srch_t;
  dcpbs_srch_t r, next_r;
  logic [3:0] err;
  // distance of the code from the centre; smallest wins
  always_comb begin
    err = (ana_in.vctl >= `DCPBS_VC_CENTER) ?
          ana_in.vctl - `DCPBS_VC_CENTER : `DCPBS_VC_CENTER - ana_in.vctl;
    next_r = r;
    case (r.st)
      ST_IDLE: begin
        if (start_in) begin
          next_r.st    = ST_SETTLE;
          next_r.band  = `DCPBS_BAND_FIRST;
          next_r.found = 1'b0;
          next_r.best  = `DCPBS_BAND_MID;
          next_r.best_err = `DCPBS_ERR_MAX;
          next_r.cnt   = '0;
        end
      end
      ST_SETTLE: begin
        // wait for loop to settle after every band step
        if (r.cnt == `DCPBS_CNT_W'(`DCPBS_SETTLE_CYC - 1)) begin
          next_r.st = ST_JUDGE;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_JUDGE: begin
        // keep locked band nearest centre: widest margin over temp
        if (ana_in.locked && (!r.found || err < r.best_err)) begin
          next_r.best     = r.band;
          next_r.best_err = err;
          next_r.found    = 1'b1;
        end
        if (r.band == `DCPBS_BAND_LAST) begin
          next_r.st = ST_DONE;
        end else begin
          next_r.band = r.band + 1'b1;
          next_r.cnt  = '0;
          next_r.st   = ST_SETTLE;
        end
      end
      ST_DONE: begin
        next_r.band = r.best;
        next_r.st   = ST_IDLE;
      end
      default: next_r.st = ST_IDLE;
    endcase
    if (abort_in) begin
      next_r.st = ST_IDLE;
    end
  end
  // state register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      r <= '{st: ST_IDLE, band: `DCPBS_BAND_MID, best: `DCPBS_BAND_MID,
             best_err: `DCPBS_ERR_MAX, found: 1'b0, cnt: '0};
    end else begin
      r <= next_r;
    end
  end
  assign busy_out = (r.st != ST_IDLE);
  assign band_out = r.band;
endmodule // dcpbs_search

//--- core/dcpbs_top.sv
// sample clock source select, multiplier control and oscillator band
// selection, configured over the byte-wide serial register port.
// assumes port strobes are synchronous one-cycle pulses on CLK_IN.
// Function
// - with the PLL enable bit clear the multiplier is powered down and the sample clock comes from the direct clock pins.
// - with the PLL enable bit set the sample clock comes from the reference input through the multiplier.
// - oscillator frequency is reference times divider factor times sample clock multiplier.
// - in multiplied mode the sample clock is reference times sample clock multiplier.
// - the oscillator span has 63 overlapping bands, best band found per device.
// - that write starts a routine choosing a band that stays locked over temperature.
// - with the manual bit set the six-bit band field drives the oscillator band directly.
// - a 4-bit control voltage code is reported, 1111 go higher, 0001 go lower, near 1001 optimal; the band search aims for 1000.
// - duty-cycle and input level correction are enabled by bits of the clock input register.
`timescale 1ns/1ps
`include "dcpbs_defs.svh"
module dcpbs_top (
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_N_IN,
  input  wire dcpbs_pkg::dcpbs_bus_t REG_BUS_IN,
  input  wire dcpbs_pkg::dcpbs_ana_t PLL_STATUS_IN,
  output logic [7:0]                 REG_RDATA_OUT,
  output logic                       REG_RVALID_OUT,
  output dcpbs_pkg::dcpbs_ctl_t      CLK_CTRL_OUT
);
  import dcpbs_pkg::*;
  typedef struct packed {
    logic [7:0] pllctl;
    logic [7:0] bias;
    logic [7:0] xctl;
    logic [7:0] clkin;
    logic [7:0] rdata;
    logic       rvalid;
    logic [5:0] band;
    dcpbs_ctl_t ctl;
  } dcpbs_top_st_t;
  dcpbs_top_st_t r, next_r;
  logic       auto_start;
  logic       srch_busy;
  logic [5:0] srch_band;
  logic       wr_pllctl;

  assign wr_pllctl = REG_BUS_IN.wr &&
                     (REG_BUS_IN.addr == `DCPBS_REG_PLLCTL);
  // enable set, manual clear: automatic band search write
  assign auto_start = wr_pllctl && REG_BUS_IN.wdata[`DCPBS_PLLCTL_EN] &&
                      !REG_BUS_IN.wdata[`DCPBS_PLLCTL_MAN];

  // band search runs on its own engine
  dcpbs_search u_search (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .start_in (auto_start),
    .abort_in (wr_pllctl && !auto_start),
    .ana_in   (PLL_STATUS_IN),
    .busy_out (srch_busy),
    .band_out (srch_band)
  );

  // register writes, read mux and derived clock controls
  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    if (REG_BUS_IN.wr) begin
      case (REG_BUS_IN.addr)
        `DCPBS_REG_PLLCTL: next_r.pllctl = REG_BUS_IN.wdata;
        `DCPBS_REG_BIAS:   next_r.bias   = REG_BUS_IN.wdata;
        `DCPBS_REG_XCTL:   next_r.xctl   = REG_BUS_IN.wdata;
        `DCPBS_REG_CLKIN:  next_r.clkin  = REG_BUS_IN.wdata;
        default: ;
      endcase
    end
    if (REG_BUS_IN.rd) begin
      next_r.rvalid = 1'b1;
      case (REG_BUS_IN.addr)
        `DCPBS_REG_PLLCTL: next_r.rdata = r.pllctl;
        `DCPBS_REG_BIAS:   next_r.rdata = r.bias;
        `DCPBS_REG_XCTL:   next_r.rdata = r.xctl;
        `DCPBS_REG_CLKIN:  next_r.rdata = r.clkin;
        // lock, search busy, band-meaning control voltage code
        `DCPBS_REG_STATUS: next_r.rdata = {PLL_STATUS_IN.locked,
                                           srch_busy, 2'b00,
                                           PLL_STATUS_IN.vctl};
        default:           next_r.rdata = 8'h00; // unmapped reads zero
      endcase
    end
    // manual bit: band field drives tuning directly
    if (r.pllctl[`DCPBS_PLLCTL_MAN]) begin
      next_r.band = r.pllctl[`DCPBS_BAND_MSB:0];
    end else begin
      next_r.band = srch_band; // result of the 63-band search
    end
    // enable clear powers multiplier down, direct pins
    next_r.ctl.pll_en   = r.pllctl[`DCPBS_PLLCTL_EN];
    next_r.ctl.use_ref  = r.pllctl[`DCPBS_PLLCTL_EN];
    next_r.ctl.band     = r.band;
    next_r.ctl.loop_bw  = r.bias[`DCPBS_BW_MSB:`DCPBS_BW_LSB];
    next_r.ctl.bias_ctl = r.bias[`DCPBS_BCTL_MSB:0];
    next_r.ctl.cross_en = r.xctl[`DCPBS_XCTL_XEN];
    next_r.ctl.dcc_en   = r.clkin[`DCPBS_CLKIN_DCC];
    next_r.ctl.lvl_en   = r.clkin[`DCPBS_CLKIN_LVL];
  end

  // single state register; frequency ratios live in analog
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      r.pllctl <= `DCPBS_RST_PLLCTL;
      r.bias   <= `DCPBS_RST_BIAS;
      r.xctl   <= `DCPBS_RST_XCTL;
      r.clkin  <= `DCPBS_RST_CLKIN;
      r.rdata  <= 8'h00;
      r.rvalid <= 1'b0;
      r.band   <= `DCPBS_BAND_MID;
      r.ctl    <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign REG_RDATA_OUT  = r.rdata;
  assign REG_RVALID_OUT = r.rvalid;
  assign CLK_CTRL_OUT   = r.ctl;
endmodule // dcpbs_top

//--- verification/dcpbs_ana_model.sv
// partner model: analog loop status as the block sees it
// assumes band and enable arrive from the block outputs
`timescale 1ns/1ps
module dcpbs_ana_model (
  input  wire dcpbs_pkg::dcpbs_ctl_t ctl_in,
  output dcpbs_pkg::dcpbs_ana_t      ana_out
);
  import dcpbs_pkg::*;
  // locks only on bands 24..39, so several bands are valid per target
  always_comb begin
    ana_out.locked = ctl_in.pll_en && ctl_in.band >= 6'h18
                     && ctl_in.band <= 6'h27;
    ana_out.vctl = ctl_in.pll_en ? ctl_in.band[3:0] : 4'h0;
  end
endmodule // dcpbs_ana_model

//--- verification/dcpbs_props.sv
// port checker for the clock control block
// assumes it is bound onto dcpbs_top and sees only its ports
`timescale 1ns/1ps
module dcpbs_props (
  input wire logic                  CLK_IN,
  input wire logic                  RST_N_IN,
  input wire dcpbs_pkg::dcpbs_bus_t REG_BUS_IN,
  input wire dcpbs_pkg::dcpbs_ana_t PLL_STATUS_IN,
  input wire logic [7:0]            REG_RDATA_OUT,
  input wire logic                  REG_RVALID_OUT,
  input wire dcpbs_pkg::dcpbs_ctl_t CLK_CTRL_OUT
);
  import dcpbs_pkg::*;
  dcpbs_bus_t b;
  dcpbs_ctl_t c;
  logic       wa;
  logic       w8;
  logic       wc;
  logic       ru;
  // aliases, write strobes and the unmapped read strobe; quiet windows cover any lag of 2..4
  assign b = REG_BUS_IN;
  assign c = CLK_CTRL_OUT;
  assign wa = b.wr && b.addr == 7'h0A;
  assign w8 = b.wr && b.addr == 7'h08;
  assign wc = b.wr && b.addr == 7'h0C;
  assign ru = b.rd && !(b.addr inside {7'h08, 7'h0A, 7'h0C, 7'h0D, 7'h0E});
  // single domain, so clock and reset are given once
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_rv; REG_RVALID_OUT == $past(b.rd); endproperty
  a_rv: assert property (p_rv) else $error("read answer late");
  property p_hold; !REG_RVALID_OUT |-> $stable(REG_RDATA_OUT); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_unm; ru |=> REG_RDATA_OUT == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not zero");
  property p_off; (wa && !b.wdata[7]) ##1 (!wa) [*4] |->
    !c.pll_en && !c.use_ref; endproperty
  a_off: assert property (p_off) else $error("pll not off");
  property p_on; wa && b.wdata[7] |-> ##[1:4] c.pll_en && c.use_ref;
  endproperty
  a_on: assert property (p_on) else $error("pll not on");
  property p_man; (wa && b.wdata[7:6] == 2'b11) ##1 (!wa) [*5] |->
    c.band == $past(b.wdata[5:0], 5); endproperty
  a_man: assert property (p_man) else $error("manual band");
  property p_dcc; w8 ##1 (!w8) [*4] |->
    {c.lvl_en, c.dcc_en} == $past(b.wdata[1:0], 4); endproperty
  a_dcc: assert property (p_dcc) else $error("input correction");
  property p_bias; wc ##1 (!wc) [*4] |->
    {c.loop_bw, c.bias_ctl} == $past(b.wdata, 4); endproperty
  a_bias: assert property (p_bias) else $error("bias fields");
endmodule // dcpbs_props
bind dcpbs_top dcpbs_props chk_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
  .REG_BUS_IN(REG_BUS_IN), .PLL_STATUS_IN(PLL_STATUS_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .CLK_CTRL_OUT(CLK_CTRL_OUT));

//--- verification/dcpbs_top_test.sv
// self-checking bench for the clock control block
// assumes the partner model feeds the analog status back
`timescale 1ns/1ps
module dcpbs_top_test;
  import dcpbs_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  dcpbs_bus_t bus = '0;
  dcpbs_ana_t ana;
  logic [7:0] rdata;
  logic       rvalid;
  dcpbs_ctl_t ctl;
  logic [7:0] v;
  int         fails = 0;
  int         total_checks = 0;
  int         i;
  // 100 MHz clock
  always #5 clk = ~clk;
  dcpbs_top dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .REG_BUS_IN(bus),
    .PLL_STATUS_IN(ana), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .CLK_CTRL_OUT(ctl));
  dcpbs_ana_model ana_u (.ctl_in(ctl), .ana_out(ana));
  // one compare for every check
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  // one-cycle write strobe, then idle for a cycle
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, 1'b1, 1'b0, d};
    @(posedge clk) bus <= '0;
  endtask
  // answer is looked at in the single cycle that rvalid stands
  task automatic rd(input logic [6:0] a, input logic [7:0] e, m);
    @(posedge clk) bus <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk) bus <= '0;
    #1 chk({7'h00, rvalid}, 8'h01);
    v = rdata;
    chk(v & m, e);
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence; long waits are bounded loops of reads
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(7'h0A, 8'h00, 8'hFF);
    rd(7'h0C, 8'hC9, 8'hFF);
    rd(7'h0D, 8'h10, 8'hFF);
    rd(7'h08, 8'h00, 8'hFF);
    wr(7'h7F, 8'h5A);
    rd(7'h7F, 8'h00, 8'hFF);
    wr(7'h0C, 8'h35);
    wr(7'h0D, 8'h00);
    wr(7'h08, 8'h03);
    repeat (6) @(posedge clk);
    chk({ctl.loop_bw, ctl.bias_ctl}, 8'h35);
    v = {4'h0, ctl.cross_en, ctl.dcc_en, ctl.lvl_en, ctl.pll_en};
    chk(v, 8'h06);
    rd(7'h08, 8'h03, 8'hFF);
    // back to the recommended bias values
    wr(7'h0C, 8'hC9);
    wr(7'h0D, 8'h10);
    repeat (6) @(posedge clk);
    chk({ctl.loop_bw, ctl.bias_ctl}, 8'hC9);
    chk({7'h00, ctl.cross_en}, 8'h01);
    $display("test reset and registers done");
    wr(7'h0A, 8'hDA);
    repeat (6) @(posedge clk);
    chk({ctl.pll_en, ctl.use_ref, ctl.band}, 8'hDA);
    rd(7'h0E, 8'h8A, 8'hFF);
    // manual calibration sweep; band 24 sits nearest mid-code
    for (i = 22; i < 27; i++) begin
      wr(7'h0A, 8'hC0 | 8'(i));
      repeat (4) @(posedge clk);
      rd(7'h0E, {(i >= 24), 3'h0, 4'(i)}, 8'hFF);
    end
    wr(7'h0A, 8'hD8);
    repeat (6) @(posedge clk);
    chk({2'b00, ctl.band}, 8'h18);
    wr(7'h0A, 8'hD0);
    repeat (6) @(posedge clk);
    rd(7'h0E, 8'h00, 8'hFF);
    wr(7'h0A, 8'h00);
    repeat (6) @(posedge clk);
    chk({6'h00, ctl.pll_en, ctl.use_ref}, 8'h00);
    $display("test manual band done");
    wr(7'h0A, 8'hC0);
    wr(7'h0A, 8'h80);
    rd(7'h0E, 8'h40, 8'h40);
    for (i = 0; i < 4000 && v[6] !== 1'b0; i++) begin
      rd(7'h0E, 8'h00, 8'h00);
    end
    // a search that never ends counts as a mismatch
    chk({7'h00, v[6]}, 8'h00);
    if (v[6] === 1'b0) begin
      rd(7'h0E, 8'h88, 8'hFF);
      chk({2'b00, ctl.band}, 8'h18);
      // restart, then abort with a manual band write
      wr(7'h0A, 8'hC0);
      wr(7'h0A, 8'h80);
      rd(7'h0E, 8'h40, 8'h40);
      wr(7'h0A, 8'hDA);
      repeat (4) @(posedge clk);
      rd(7'h0E, 8'h8A, 8'hFF);
    end
    $display("test auto band done");
    final_report();
  end
endmodule // dcpbs_top_test
